//--- pldt_pkg.sv
// pin level duration timer: shared constants and carrier types
// assumes a single 10 MHz clock domain and sixteen general pins
package pldt_pkg;

  // ----------------------------------------------------------------
  // clock and tick timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 100000;
  localparam int TICK_BASE_PS     = 2000000;
  localparam int TICK_MID_PS      = 800000;
  localparam int TICK_FAST_PS     = 750000;
  localparam int TICK_BASE_CYC    = TICK_BASE_PS / CLK_PERIOD_PS;
  localparam int TICK_MID_CYC     = TICK_MID_PS / CLK_PERIOD_PS;
  localparam int TICK_FAST_CYC    = TICK_FAST_PS / CLK_PERIOD_PS;

  // ----------------------------------------------------------------
  // widths and result values
  // ----------------------------------------------------------------
  localparam int PIN_COUNT        = 16;
  localparam int SEL_W            = 4;
  localparam int CNT_W            = 16;
  localparam logic [CNT_W-1:0] CNT_MAX    = 16'hFFFF;
  localparam logic [CNT_W-1:0] RES_RESET  = 16'h0000;
  localparam logic [CNT_W-1:0] RES_OVFL   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_FIRST  = 16'h0001;
  localparam logic [1:0]       SETTLE_LAST = 2'h2;

  typedef enum logic [1:0] {
    PLDT_VAR_BASE,
    PLDT_VAR_MID,
    PLDT_VAR_FAST
  } pldt_variant_t;

  typedef struct packed {
    logic [SEL_W-1:0] pin_sel;
    logic             level;
  } pldt_cmd_t;

  typedef struct packed {
    logic [CNT_W-1:0] count;
    logic             done;
  } pldt_res_t;

endpackage : pldt_pkg

//--- pldt_rc_net.sv
// pin level duration timer: external rc network model
// assumes go charges the selected pin; other pins sit off level
`timescale 1ns/1ps
module pldt_rc_net (
  input wire logic        clk,
  input wire logic [3:0]  sel,
  input wire logic        level,
  input wire logic [31:0] hold,
  input wire logic        go,
  output logic [15:0]     pins
);
  logic [31:0] left_q;
  always_ff @(posedge clk) begin
    if (go) left_q <= hold;
    else if (left_q != 0) left_q <= left_q - 32'h1;
  end
  always_comb begin
    pins = {16{~level}};
    pins[sel] = (left_q != 0) ? level : ~level;
  end
endmodule : pldt_rc_net

//--- pldt_tick_gen.sv
// pin level duration timer: tick enable divider
// assumes clk from pldt_pkg timing; restarts on clear so first tick is a full period
`timescale 1ns/1ps
module pldt_tick_gen #(
  parameter int DIV_W = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clear,
  input  wire logic [DIV_W-1:0] period,
  output logic                  tick
);
  import pldt_pkg::*;

  logic [DIV_W-1:0] div_q;

  // a one-bit divider cannot tell a full period from a restart
  if (DIV_W < 2) begin : g_width_chk
    $error("pldt_tick_gen: DIV_W too small");
  end

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= '0;
      tick  <= 1'b0;
    end else if (clear) begin
      div_q <= '0;
      tick  <= 1'b0;
    end else if (div_q >= period - DIV_W'(1)) begin
      div_q <= '0;
      tick  <= 1'b1;
    end else begin
      div_q <= div_q + DIV_W'(1);
      tick  <= 1'b0;
    end
  end

endmodule : pldt_tick_gen

//--- pldt_timer.sv
// pin level duration timer: top level
// assumes pins come from outside the clock domain; start is a one-cycle pulse on clk
// assumes the selected pin already sits at the requested level when start comes
`timescale 1ns/1ps
module pldt_timer #(
  parameter pldt_pkg::pldt_variant_t    VARIANT   = pldt_pkg::PLDT_VAR_BASE,
  parameter logic [pldt_pkg::CNT_W-1:0] CNT_LIMIT = pldt_pkg::CNT_MAX
) (
  input  wire logic                                 clk,
  input  wire logic                                 reset_n,
  input  wire logic                                 start,
  input  wire pldt_pkg::pldt_cmd_t                  cmd,
  input  wire logic [pldt_pkg::PIN_COUNT-1:0]       pin_in,
  output logic      [pldt_pkg::PIN_COUNT-1:0]       pin_oe,
  output pldt_pkg::pldt_res_t                       result,
  output logic                                      busy
);
  import pldt_pkg::*;

  localparam int DIV_W = 8;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETTLE,
    ST_RUN
  } pldt_state_t;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [DIV_W-1:0] tick_period(input pldt_variant_t v);
    unique case (v)
      PLDT_VAR_BASE: tick_period = DIV_W'(TICK_BASE_CYC);
      PLDT_VAR_MID:  tick_period = DIV_W'(TICK_MID_CYC);
      PLDT_VAR_FAST: tick_period = DIV_W'(TICK_FAST_CYC);
      default:       tick_period = DIV_W'(TICK_BASE_CYC);
    endcase
  endfunction : tick_period

  // one step of the tick count; wraps at the top, though the register stops at CNT_LIMIT and never wraps
  function automatic logic [CNT_W-1:0] count_next(input logic [CNT_W-1:0] n);
    count_next = n + CNT_FIRST;
  endfunction : count_next

  pldt_state_t              state_q;
  logic [PIN_COUNT-1:0]     sync1_q;
  logic [PIN_COUNT-1:0]     sync2_q;
  logic [SEL_W-1:0]         sel_q;
  logic                     level_q;
  logic [CNT_W-1:0]         cnt_q;
  logic [1:0]               settle_q;
  logic                     tick;
  logic                     clear;
  logic                     off_level;
  logic                     run_tick;
  logic                     hit_limit;
  logic                     hit_off;
  logic                     finish;

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  // every selector code must address a real pin
  if (PIN_COUNT != (1 << SEL_W)) begin : g_pin_chk
    $error("pldt_timer: pin count does not match selector width");
  end
  // the divider cannot count to a period wider than its own register
  if ((TICK_BASE_CYC >= (1 << DIV_W)) || (TICK_MID_CYC >= (1 << DIV_W)) ||
      (TICK_FAST_CYC < 1)) begin : g_div_chk
    $error("pldt_timer: tick period does not fit the divider");
  end
  // a zero limit would end every run on its first tick
  if (CNT_LIMIT == '0) begin : g_lim_chk
    $error("pldt_timer: count limit must not be zero");
  end

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  assign off_level = (sync2_q[sel_q] != level_q);
  assign clear     = (state_q != ST_RUN);

  pldt_tick_gen #(
    .DIV_W (DIV_W)
  ) u_tick (
    .clk     (clk),
    .reset_n (reset_n),
    .clear   (clear),
    .period  (tick_period(VARIANT)),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // operand capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q   <= '0;
      level_q <= 1'b0;
    end else if (state_q == ST_IDLE && start) begin
      sel_q   <= cmd.pin_sel;
      level_q <= cmd.level;
    end
  end

  // ----------------------------------------------------------------
  // pin direction
  // ----------------------------------------------------------------
  // the block never drives pins; selected one is forced to input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_oe <= '0;
    end else begin
      pin_oe <= '0;
    end
  end

  // ----------------------------------------------------------------
  // measurement decisions
  // ----------------------------------------------------------------
  // pin is looked at only on tick edges, never between them
  // the limit wins over the pin so a run past the limit reports zero
  // even when the pin happens to leave on that very tick
  assign run_tick  = (state_q == ST_RUN) && tick;
  assign hit_limit = run_tick && (cnt_q == CNT_LIMIT);
  assign hit_off   = run_tick && off_level && !hit_limit;
  assign finish    = hit_limit || hit_off;

  // ----------------------------------------------------------------
  // state sequence
  // ----------------------------------------------------------------
  // settle waits out the two synchroniser stages after the pin goes input
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          if (settle_q == SETTLE_LAST) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (finish) begin
            state_q <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // settle counter
  // ----------------------------------------------------------------
  // counts only in settle; parked at zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_q <= '0;
    end else if (state_q == ST_SETTLE) begin
      settle_q <= settle_q + 2'h1;
    end else begin
      settle_q <= '0;
    end
  end

  // ----------------------------------------------------------------
  // tick count
  // ----------------------------------------------------------------
  // cleared while idle so every run starts from zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (state_q == ST_IDLE) begin
      cnt_q <= '0;
    end else if (run_tick && !finish) begin
      cnt_q <= count_next(cnt_q);
    end
  end

  // ----------------------------------------------------------------
  // result
  // ----------------------------------------------------------------
  // count holds between runs; done is a single-cycle strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      result <= '{count: RES_RESET, done: 1'b0};
    end else begin
      result.done <= finish;
      if (hit_limit) begin
        result.count <= RES_OVFL;
      end else if (hit_off) begin
        // the detecting tick counts, so an early exit yields one
        result.count <= count_next(cnt_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // busy flag
  // ----------------------------------------------------------------
  // busy falls with done so the next start may follow on the next cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else if (state_q == ST_IDLE && start) begin
      busy <= 1'b1;
    end else if (finish) begin
      busy <= 1'b0;
    end
  end

endmodule : pldt_timer

//--- pldt_timer_sva.sv
// pin level duration timer: port checker
// assumes one clock domain and the registered outputs of pldt_timer
`timescale 1ns/1ps
module pldt_timer_sva #(
  parameter pldt_pkg::pldt_variant_t VARIANT   = pldt_pkg::PLDT_VAR_BASE,
  parameter logic [15:0]             CNT_LIMIT = 16'hFFFF
) (
  input wire logic                 clk,
  input wire logic                 reset_n,
  input wire logic                 start,
  input wire logic [15:0]          pin_oe,
  input wire pldt_pkg::pldt_res_t  result,
  input wire logic                 busy
);
  import pldt_pkg::*;
  localparam int P = (VARIANT == PLDT_VAR_BASE) ? TICK_BASE_CYC :
                     (VARIANT == PLDT_VAR_MID) ? TICK_MID_CYC : TICK_FAST_CYC;
  // zero may only come once the limit has been passed
  localparam int OVF_CYC = (int'(CNT_LIMIT) + 1) * P;
  logic [31:0] cyc_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // busy cycles of the last run, bounds the tick count from above
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) cyc_q <= '0;
    else if (start && !busy) cyc_q <= '0;
    else if (busy) cyc_q <= cyc_q + 32'h1;
  end
  sequence s_launch;
    start && !busy;
  endsequence
  a_pins_input: assert property (pin_oe == 16'h0000)
    else $error("pin driven");
  a_launch_busy: assert property (s_launch |=> busy [*4])
    else $error("busy too short");
  a_done_ends: assert property (result.done |-> !busy && $past(busy))
    else $error("done not at end");
  a_done_pulse: assert property (result.done |=> !result.done)
    else $error("done too long");
  a_count_hold: assert property (!result.done |-> $stable(result.count))
    else $error("count moved");
  a_idle_quiet: assert property (!busy && !$past(busy) |-> !result.done)
    else $error("done while idle");
  a_tick_space: assert property (result.done |-> cyc_q >= 32'(result.count) * P)
    else $error("ticks too fast");
  a_ovfl_zero: assert property (result.done && result.count == 16'h0000 |->
    cyc_q >= 32'(OVF_CYC))
    else $error("early zero");
endmodule : pldt_timer_sva
bind pldt_timer pldt_timer_sva #(.VARIANT(VARIANT), .CNT_LIMIT(CNT_LIMIT)) u_sva (.clk(clk),
  .reset_n(reset_n),
  .start(start), .pin_oe(pin_oe), .result(result), .busy(busy));

//--- pldt_timer_tb.sv
// pin level duration timer: self-checking bench
// assumes base variant at 20 clocks per tick, plus a fast variant with a short limit
`timescale 1ns/1ps
module pldt_timer_tb;
  import pldt_pkg::*;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic        start = 1'b0;
  logic        go = 1'b0;
  logic [31:0] hold = '0;
  pldt_cmd_t   cmd = '0;
  logic [15:0] pin_in;
  logic [15:0] pin_oe;
  pldt_res_t   result;
  logic        busy;
  logic [15:0] c;
  localparam logic [15:0] LIM = 16'h000F;
  logic [15:0] oe_l;
  pldt_res_t   res_l;
  logic        busy_l;
  logic [15:0] c_l;
  int          mismatches = 0;
  int          check_count = 0;
  always #50 clk = ~clk;
  pldt_timer dut (.clk(clk), .reset_n(reset_n), .start(start), .cmd(cmd),
    .pin_in(pin_in), .pin_oe(pin_oe), .result(result), .busy(busy));
  pldt_rc_net rc (.clk(clk), .sel(cmd.pin_sel), .level(cmd.level), .hold(hold),
    .go(go), .pins(pin_in));
  // fast variant with a short limit, so the zero result is reachable in a short run
  pldt_timer #(.VARIANT(PLDT_VAR_FAST), .CNT_LIMIT(LIM)) dut_lim (.clk(clk), .reset_n(reset_n),
    .start(start), .cmd(cmd), .pin_in(pin_in), .pin_oe(oe_l), .result(res_l), .busy(busy_l));
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic check(input string what, input logic [15:0] lo, input logic [15:0] hi,
                       input logic [15:0] got);
    check_count++;
    if (!(got >= lo && got <= hi) || $isunknown(got)) begin
      mismatches++;
      $display("[FAIL] %s expected %h..%h seen %h", what, lo, hi, got);
    end
  endtask : check
  // charge, launch, and a refused relaunch while busy
  task automatic measure(input logic [3:0] sel, input logic lvl, input int dur);
    int n;
    cmd = '{pin_sel: sel, level: lvl};
    hold = dur;
    go = 1'b1;
    step(1);
    go = 1'b0;
    step(4);
    start = 1'b1;
    step(1);
    start = 1'b0;
    check("busy", 16'h0001, 16'h0001, 16'(busy));
    step(5);
    start = busy;
    step(1);
    start = 1'b0;
    n = 0;
    while (result.done !== 1'b1 && n < 40000) begin
      step(1);
      n++;
    end
    c = result.count;
    c_l = res_l.count;
    check("done", 16'h0001, 16'h0001, 16'(result.done));
    check("busy end", 16'h0000, 16'h0000, 16'(busy));
    check("busy lim", 16'h0000, 16'h0000, 16'(busy_l));
    check("oe", 16'h0000, 16'h0000, pin_oe);
    check("oe lim", 16'h0000, 16'h0000, oe_l);
  endtask : measure
  task automatic t_immediate;
    for (int l = 0; l < 2; l++) begin
      measure(4'h5, l[0], 0);
      check("immediate", 16'h0001, 16'h0001, c);
      check("immediate lim", 16'h0001, 16'h0001, c_l);
    end
  endtask : t_immediate
  task automatic t_timed;
    measure(4'h0, 1'b1, 405);
    check("pin0", 16'h0014, 16'h0015, c);
    check("pin0 lim", 16'h0000, 16'h0000, c_l);
    measure(4'hF, 1'b0, 205);
    check("pin15", 16'h000A, 16'h000B, c);
    check("pin15 lim", 16'h0000, 16'h0000, c_l);
    measure(4'h7, 1'b1, 80);
    check("pin7", 16'h0004, 16'h0005, c);
    check("pin7 fast", 16'h000B, 16'h000C, c_l);
  endtask : t_timed
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    #5_000_000;
    mismatches++;
    final_report();
  end
  initial begin
    step(6);
    reset_n = 1'b1;
    step(2);
    t_immediate();
    t_timed();
    final_report();
  end
endmodule : pldt_timer_tb
